// ---- rtl/rpt_policy_ctrl.v ----
// Purpose: root port inbound/outbound transaction policy and its configuration registers
// Assumes: one core clock; request inputs come from same-clock logic; dmi_mode_i is a pin
// Notes:   one cycle from request to classified fabric request
//          read ordering and completion splitting are levels for the queues downstream
//          timeout, L0s and interrupt outputs are enables for logic outside this block
//          DMI mode lags its pin by two edges through the synchroniser
//
// Contract
// RULE1: Allocating-write bit chooses allocating or non-allocating flow for qualifying VC0/VCp writes.
// RULE2: No prefetch hint is sent for a write taking the allocating flow.
// RULE3: VCp requests with NS=1 go non-snooped only if VCp no-snoop is enabled.
// RULE4: Isoch no-snoop block stops VC1/VCm NS=1 requests going non-snooped.
// RULE5: VC0/VCp NS writes go non-snoop if write no-snoop enabled, else by allocation policy.
// RULE6: VC0/VCp NS reads go non-snoop if read no-snoop enabled, else snooped reads.
// RULE7: With an honoured hint, NS and both no-snoop enables are ignored.
// RULE8: VC1 and VCm requests are non-snoop regardless of the no-snoop enable bits.
// RULE9: Read in-order bit forbids any read bypassing an earlier read.
// RULE10: Hint-disable bit makes TPH=1 requests behave as TPH=0.
// RULE11: DCA override skips requester match; all writes are DCA, target from tag. Code makes only VC0/VCp writes DCA; VC1/VCm writes never are.
// RULE12: Transmitter low-power block keeps the transmitter out of L0s always.
// RULE13: Config timeout enable, set at reset, gates config completion timeouts alone.
// RULE14: All-timeouts-off bit disables every completion timeout.
// RULE15: Link bandwidth interrupt suppress stops MSI/INTx from link status bits 15,14.
// RULE16: Peer read block master-aborts peer-to-peer memory reads.
// RULE17: On the DMI port, hold-disable answers hold messages with UR and fatal error.
// RULE18: Outbound class clear forces outbound TC to zero, else passes it.
// RULE19: In DMI mode outbound TC is always zero.
// RULE20: Long-header check flags 4DW headers below 4 GB as malformed.
// RULE21: No-combine bit returns read completions split at 64-byte cacheline boundaries.
// RULE22: Undescribed bits read zero and ignore writes; fields reset to defaults.
`include "rpt_regs.vh"
`timescale 1ns/1ns
`default_nettype none
module rpt_policy_ctrl #(
  parameter       DMI_PORT = 0, // 1 when this port is the DMI port
  parameter [7:0] TAG_W    = 8  // width of the inbound tag
) (
  input  wire             ref_clk_i,        // core clock, 100 MHz
  input  wire             reset_i,          // sync reset, high
  input  wire             dmi_mode_i,       // pin: port runs in DMI mode
  // configuration space port
  input  wire             cfg_req_i,        // access request
  input  wire             cfg_wr_i,         // 1 write, 0 read
  input  wire [11:0]      cfg_addr_i,       // byte address
  input  wire [3:0]       cfg_be_i,         // byte enables
  input  wire [31:0]      cfg_wdata_i,      // write data
  output reg              cfg_ack_o,        // access done
  output reg  [31:0]      cfg_rdata_o,      // read data
  // inbound request from the link
  input  wire             ib_valid_i,       // request present
  input  wire             ib_write_i,       // 1 write, 0 read
  input  wire [1:0]       ib_vc_i,          // 0 VC0, 1 VCp, 2 VC1, 3 VCm
  input  wire             ib_ns_i,          // no-snoop attribute
  input  wire             ib_tph_i,         // processing hint present
  input  wire [TAG_W-1:0] ib_tag_i,         // tag field
  input  wire             ib_dca_match_i,   // requester matched a DCA id
  input  wire             ib_peer_i,        // decodes as peer-to-peer
  input  wire             ib_hdr4dw_i,      // 4DW header
  input  wire             ib_addr_hi_zero_i,// upper 32 address bits zero
  input  wire             cip_hint_zero_i,  // coherent_if_ctrl zero-tag hint bit
  input  wire             hold_msg_i,       // assert-hold message received
  // outbound request
  input  wire             ob_valid_i,       // outbound request present
  input  wire [2:0]       ob_tc_i,          // source traffic class
  input  wire             link_l0s_en_i,    // link control enables L0s
  // classified fabric request
  output reg              fab_valid_o,      // classified request
  output reg  [2:0]       fab_op_o,         // request kind
  output reg              fab_prefetch_o,   // send prefetch hint
  output reg              fab_dca_en_o,     // DCA enabled for write
  output reg  [TAG_W-1:0] fab_dca_tgt_o,    // DCA target from tag
  output reg              fab_abort_o,      // master abort pulse
  output reg              malformed_o,      // malformed TLP pulse
  output reg              rd_inorder_o,     // reads must stay in order
  output reg              hold_ur_o,        // answer hold with UR
  output reg              fatal_err_o,      // fatal error pulse
  output reg              ob_valid_o,       // outbound request out
  output reg  [2:0]       ob_tc_o,          // outbound traffic class
  output reg              tx_l0s_allow_o,   // transmitter may enter L0s
  output reg              cfg_timeout_en_o, // config completion timeouts on
  output reg              other_timeout_en_o,// other completion timeouts on
  output reg              lbw_irq_allow_o,  // link bw status may interrupt
  output reg              cpl_no_combine_o, // split completions per line
  output reg  [6:0]       cpl_max_bytes_o   // largest completion, 0 unlimited
);
  wire        dmi_mode_s;
  wire [31:0] reg_val [0:2];
  wire [2:0]  reg_hit;
  wire [31:0] pol_a;
  wire [31:0] pol_b;
  wire [31:0] misc;

  rpt_sync2 u_dmi_sync (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .async_i   (dmi_mode_i),
    .sync_o    (dmi_mode_s)
  );

  // One access per cycle; every request is acknowledged, mapped or not
  wire wr_take = cfg_req_i & cfg_wr_i;
  wire rd_take = cfg_req_i & ~cfg_wr_i;

  assign reg_hit[0] = (cfg_addr_i == `RPT_OFS_POLICY_A);
  assign reg_hit[1] = (cfg_addr_i == `RPT_OFS_POLICY_B);
  assign reg_hit[2] = (cfg_addr_i == `RPT_OFS_MISC);

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_reg
      // Reset values and writable masks per register
      localparam [31:0] RV = (gi == 0) ? `RPT_RST_POLICY_A :
                             (gi == 1) ? `RPT_RST_POLICY_B : `RPT_RST_MISC;
      localparam [31:0] WM = (gi == 0) ? `RPT_WM_POLICY_A :
                             (gi == 1) ? `RPT_WM_POLICY_B : `RPT_WM_MISC;
      rpt_cfg_word #(
        .RESET (RV),
        .WMASK (WM)
      ) u_word (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .we_i      (wr_take & reg_hit[gi]), // see RULE22
        .be_i      (cfg_be_i),
        .wdata_i   (cfg_wdata_i),
        .value_o   (reg_val[gi])
      );
    end
  endgenerate

  assign pol_a = reg_val[0];
  assign pol_b = reg_val[1];
  assign misc  = reg_val[2];

  // Config read: unmapped offsets answer zero
  reg [31:0] rdata_d;
  always @* begin
    rdata_d = 32'h00000000;
    if (reg_hit[0]) begin
      rdata_d = pol_a;
    end else if (reg_hit[1]) begin
      rdata_d = pol_b;
    end else if (reg_hit[2]) begin
      rdata_d = misc; // see RULE22
    end
  end

  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      cfg_ack_o   <= 1'b0;
      cfg_rdata_o <= 32'h00000000;
    end else begin
      cfg_ack_o   <= cfg_req_i;
      cfg_rdata_o <= rd_take ? rdata_d : 32'h00000000;
    end
  end

  // Field decode
  wire alloc_wr   = pol_a[`RPT_A_ALLOC_WR];
  wire vcp_ns_en  = pol_a[`RPT_A_VCP_NS_EN];
  wire isoch_blk  = pol_a[`RPT_A_ISOCH_NS_BLK];
  wire wr_ns_en   = pol_a[`RPT_A_WR_NS_EN];
  wire rd_ns_en   = pol_a[`RPT_A_RD_NS_EN];
  wire hint_dis   = pol_b[`RPT_B_HINT_DIS];
  wire dca_ovr    = pol_b[`RPT_B_DCA_OVR];

  // Inbound classification
  wire isoch      = ib_vc_i[1];
  wire is_vcp     = (ib_vc_i == 2'b01);
  wire tph_eff    = ib_tph_i & ~hint_dis;                       // see RULE10
  wire zero_hint  = tph_eff & (ib_tag_i == {TAG_W{1'b0}}) & cip_hint_zero_i;
  wire ns_ok      = ib_ns_i & ~tph_eff & (~is_vcp | vcp_ns_en); // see RULE3
  wire is_dca     = ib_write_i & (dca_ovr | ib_dca_match_i);    // see RULE11
  wire malformed  = misc[`RPT_M_LONG_HDR_CHK] & ib_hdr4dw_i & ib_addr_hi_zero_i;
  wire peer_abort = misc[`RPT_M_PEER_RD_BLK] & ib_peer_i & ~ib_write_i;

  reg [2:0] op_d;
  always @* begin
    op_d = `RPT_OP_SNP_RD;
    if (isoch) begin
      // Isoch traffic is non-snoop unless NS=1 is blocked
      if (ib_ns_i & isoch_blk) begin                            // see RULE4
        op_d = ib_write_i ? `RPT_OP_NALLOC_WR : `RPT_OP_SNP_RD;
      end else begin
        op_d = ib_write_i ? `RPT_OP_NS_WR : `RPT_OP_NS_RD;      // see RULE8
      end
    end else if (ib_write_i) begin
      if (is_dca) begin
        op_d = `RPT_OP_DCA_WR;
      end else if (tph_eff & ~zero_hint) begin
        op_d = `RPT_OP_HINT_WR;                                 // see RULE7
      end else if (ns_ok & wr_ns_en) begin
        op_d = `RPT_OP_NS_WR;                                   // see RULE5
      end else begin
        op_d = alloc_wr ? `RPT_OP_ALLOC_WR : `RPT_OP_NALLOC_WR; // see RULE1
      end
    end else begin
      if (tph_eff) begin
        op_d = `RPT_OP_HINT_RD;                                 // see RULE7
      end else if (ns_ok & rd_ns_en) begin
        op_d = `RPT_OP_NS_RD;                                   // see RULE6
      end else begin
        op_d = `RPT_OP_SNP_RD;
      end
    end
  end

  // Next values of the inbound answer
  wire ib_take     = ib_valid_i & ~malformed;
  // Malformed or aborted requests never reach the fabric
  wire fab_valid_d = ib_take & ~peer_abort;
  wire abort_d     = ib_take & peer_abort;                       // see RULE16
  wire malformed_d = ib_valid_i & malformed;                     // see RULE20
  // DCA covers VC0/VCp writes only; the target reads zero otherwise
  wire dca_wr      = ib_take & ~isoch & is_dca;                  // see RULE11
  // Prefetch hint only for the non-allocating flow
  wire prefetch_d  = ib_take & ~isoch & (op_d == `RPT_OP_NALLOC_WR); // see RULE2

  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      fab_valid_o    <= 1'b0;
      fab_op_o       <= `RPT_OP_SNP_RD;
      fab_prefetch_o <= 1'b0;
      fab_dca_en_o   <= 1'b0;
      fab_dca_tgt_o  <= {TAG_W{1'b0}};
      fab_abort_o    <= 1'b0;
      malformed_o    <= 1'b0;
    end else begin
      fab_valid_o    <= fab_valid_d;
      fab_op_o       <= op_d;
      fab_prefetch_o <= prefetch_d;
      fab_dca_en_o   <= dca_wr;
      fab_dca_tgt_o  <= dca_wr ? ib_tag_i : {TAG_W{1'b0}};       // see RULE11
      fab_abort_o    <= abort_d;
      malformed_o    <= malformed_d;
    end
  end

  // Hold message handling, DMI port only
  wire hold_refuse = (DMI_PORT != 0) & misc[`RPT_M_HOLD_DIS] & hold_msg_i;

  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      hold_ur_o   <= 1'b0;
      fatal_err_o <= 1'b0;
    end else begin
      hold_ur_o   <= hold_refuse;                                // see RULE17
      fatal_err_o <= hold_refuse;                                // see RULE17
    end
  end

  // Outbound class; DMI mode overrides the register bit
  reg [2:0] ob_tc_d;
  always @* begin
    ob_tc_d = ob_tc_i;
    if (dmi_mode_s) begin
      ob_tc_d = 3'h0;                                            // see RULE19
    end else if (misc[`RPT_M_OB_TC_CLR]) begin
      ob_tc_d = 3'h0;                                            // see RULE18
    end
  end

  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      ob_valid_o <= 1'b0;
      ob_tc_o    <= 3'h0;
    end else begin
      ob_valid_o <= ob_valid_i;
      ob_tc_o    <= ob_tc_d;
    end
  end

  // Next values of the static policy levels
  wire       inorder_d   = pol_a[`RPT_A_RD_INORDER];                 // see RULE9
  wire       l0s_allow_d = link_l0s_en_i & ~misc[`RPT_M_TX_LP_BLK];  // see RULE12
  // Global disable wins over the config enable
  wire       cfg_to_d    = misc[`RPT_M_CFG_TO_ON]
                           & ~misc[`RPT_M_ALL_TO_OFF];               // see RULE13
  wire       other_to_d  = ~misc[`RPT_M_ALL_TO_OFF];                 // see RULE14
  wire       lbw_allow_d = ~misc[`RPT_M_LBW_IRQ_SUP];                // see RULE15
  wire       no_comb_d   = misc[`RPT_M_NO_COMBINE];                  // see RULE21
  wire [6:0] max_bytes_d = no_comb_d ? `RPT_CACHELINE_B : 7'h00;     // see RULE21

  // Static policy levels
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      rd_inorder_o       <= 1'b0;
      tx_l0s_allow_o     <= 1'b0;
      cfg_timeout_en_o   <= 1'b0;
      other_timeout_en_o <= 1'b0;
      lbw_irq_allow_o    <= 1'b0;
      cpl_no_combine_o   <= 1'b0;
      cpl_max_bytes_o    <= 7'h00;
    end else begin
      rd_inorder_o       <= inorder_d;
      tx_l0s_allow_o     <= l0s_allow_d;
      cfg_timeout_en_o   <= cfg_to_d;
      other_timeout_en_o <= other_to_d;
      lbw_irq_allow_o    <= lbw_allow_d;
      cpl_no_combine_o   <= no_comb_d;
      cpl_max_bytes_o    <= max_bytes_d;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/rpt_regs.vh ----
// Purpose: offsets, field positions, reset values and op codes of the root port policy block
// Assumes: byte addresses in configuration space
// Notes:   definitions only
`ifndef RPT_REGS_VH
`define RPT_REGS_VH

`define RPT_OFS_POLICY_A   12'h180
`define RPT_OFS_POLICY_B   12'h184
`define RPT_OFS_MISC       12'h188

`define RPT_RST_POLICY_A   32'h00183091
`define RPT_RST_POLICY_B   32'h00000000
`define RPT_RST_MISC       32'h60100000

`define RPT_WM_POLICY_A    32'h001F3FFF
`define RPT_WM_POLICY_B    32'h00000308
`define RPT_WM_MISC        32'hF9F40000

// inbound_policy_ctrl_a
`define RPT_A_ALLOC_WR     7
`define RPT_A_VCP_NS_EN    6
`define RPT_A_ISOCH_NS_BLK 5
`define RPT_A_WR_NS_EN     3
`define RPT_A_RD_NS_EN     2
`define RPT_A_RD_INORDER   1
// inbound_policy_ctrl_b
`define RPT_B_HINT_DIS     9
`define RPT_B_DCA_OVR      8
// port_misc_ctrl
`define RPT_M_TX_LP_BLK    31
`define RPT_M_CFG_TO_ON    29
`define RPT_M_ALL_TO_OFF   28
`define RPT_M_LBW_IRQ_SUP  27
`define RPT_M_PEER_RD_BLK  24
`define RPT_M_HOLD_DIS     23
`define RPT_M_OB_TC_CLR    21
`define RPT_M_LONG_HDR_CHK 20
`define RPT_M_NO_COMBINE   18

// Fabric request kinds
`define RPT_OP_ALLOC_WR    3'h0
`define RPT_OP_NALLOC_WR   3'h1
`define RPT_OP_NS_WR       3'h2
`define RPT_OP_HINT_WR     3'h3
`define RPT_OP_SNP_RD      3'h4
`define RPT_OP_NS_RD       3'h5
`define RPT_OP_HINT_RD     3'h6
`define RPT_OP_DCA_WR      3'h7

`define RPT_CACHELINE_B    7'h40

`endif

// ---- rtl/rpt_sync2.v ----
// Purpose: two flip-flop synchroniser for a level from a pin
// Assumes: input is quasi-static
// Notes:   first stage feeds only the second
`timescale 1ns/1ns
`default_nettype none
module rpt_sync2 (
  input  wire ref_clk_i, // core clock
  input  wire reset_i,   // sync reset, high
  input  wire async_i,   // pin level
  output reg  sync_o     // synchronised level
);
  reg meta_q;

  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      meta_q <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/rpt_cfg_word.v ----
// Purpose: one 32-bit configuration register with byte enables
// Assumes: write strobe already decoded for this offset
// Notes:   bits outside WMASK hold their reset value
`timescale 1ns/1ns
`default_nettype none
module rpt_cfg_word #(
  parameter [31:0] RESET = 32'h00000000,
  parameter [31:0] WMASK = 32'hFFFFFFFF
) (
  input  wire        ref_clk_i, // core clock
  input  wire        reset_i,   // sync reset, high
  input  wire        we_i,      // write this word
  input  wire [3:0]  be_i,      // byte enables
  input  wire [31:0] wdata_i,   // write data
  output reg  [31:0] value_o    // stored value
);
  wire [31:0] lane_mask;
  wire [31:0] wr_mask;

  assign lane_mask = {{8{be_i[3]}}, {8{be_i[2]}}, {8{be_i[1]}}, {8{be_i[0]}}};
  assign wr_mask   = lane_mask & WMASK;

  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      value_o <= RESET;
    end else if (we_i) begin
      value_o <= (value_o & ~wr_mask) | (wdata_i & wr_mask);
    end
  end
endmodule
`default_nettype wire

// ---- dv/rpt_policy_ctrl_assertions.sv ----
// Purpose: port-level checks for rpt_policy_ctrl
// Assumes: one core clock, synchronous reset active high
// Notes:   bound to every instance of the design
`timescale 1ns/1ns
`default_nettype none
`include "rpt_regs.vh"
module rpt_policy_chk (
  input wire logic       ref_clk_i, // clock
  input wire logic       reset_i, // reset
  input wire logic       cfg_req_i, // cfg request
  input wire logic       cfg_ack_o, // cfg ack
  input wire logic       ib_valid_i, // inbound
  input wire logic       ib_hdr4dw_i, // long header
  input wire logic       ib_addr_hi_zero_i, // low address
  input wire logic       fab_valid_o, // fabric request
  input wire logic [2:0] fab_op_o, // request kind
  input wire logic       fab_prefetch_o, // prefetch hint
  input wire logic       malformed_o, // malformed
  input wire logic       hold_msg_i, // hold message
  input wire logic       hold_ur_o, // hold refused
  input wire logic       fatal_err_o, // fatal error
  input wire logic       ob_valid_i, // outbound in
  input wire logic [2:0] ob_tc_i, // class in
  input wire logic       ob_valid_o, // outbound out
  input wire logic [2:0] ob_tc_o, // class out
  input wire logic       link_l0s_en_i, // link allows L0s
  input wire logic       tx_l0s_allow_o, // L0s allowed
  input wire logic       cfg_timeout_en_o, // cfg timeouts
  input wire logic       other_timeout_en_o, // other timeouts
  input wire logic       cpl_no_combine_o, // split completions
  input wire logic [6:0] cpl_max_bytes_o // largest completion
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);

  a_cfg_ack_once: assert property (cfg_req_i ##1 !cfg_req_i |-> cfg_ack_o ##1 !cfg_ack_o)
    else $error("config ack is not a single pulse");
  a_alloc_no_prefetch: assert property (fab_valid_o && fab_op_o == `RPT_OP_ALLOC_WR |-> !fab_prefetch_o)
    else $error("prefetch hint with allocating write");
  a_tc_pass_zero: assert property (ob_valid_i |=> ob_valid_o && (ob_tc_o == 3'h0 || ob_tc_o == $past(ob_tc_i)))
    else $error("outbound class neither passed nor zero");
  a_l0s_link_off: assert property (!link_l0s_en_i [*2] |-> !tx_l0s_allow_o)
    else $error("L0s allowed while link control forbids it");
  a_timeouts_all_off: assert property (!other_timeout_en_o |-> !cfg_timeout_en_o)
    else $error("config timeout on while all timeouts off");
  a_cpl_line_size: assert property (cpl_max_bytes_o == (cpl_no_combine_o ? `RPT_CACHELINE_B : 7'h00))
    else $error("completion size limit wrong");
  a_hold_refused: assert property (hold_ur_o |-> fatal_err_o && $past(hold_msg_i))
    else $error("hold refusal without message or fatal error");
  a_malformed_only: assert property (malformed_o |-> !fab_valid_o && $past(ib_valid_i && ib_hdr4dw_i && ib_addr_hi_zero_i))
    else $error("malformed flag without long low header");

  c_ns_write: cover property (fab_valid_o && fab_op_o == `RPT_OP_NS_WR);
  c_malformed: cover property (malformed_o);
  c_hold_refused: cover property (hold_ur_o);
endmodule
bind rpt_policy_ctrl rpt_policy_chk u_rpt_policy_chk (
  .ref_clk_i, .reset_i, .cfg_req_i, .cfg_ack_o, .ib_valid_i, .ib_hdr4dw_i, .ib_addr_hi_zero_i, .fab_valid_o,
  .fab_op_o, .fab_prefetch_o, .malformed_o, .hold_msg_i, .hold_ur_o, .fatal_err_o, .ob_valid_i, .ob_tc_i,
  .ob_valid_o, .ob_tc_o, .link_l0s_en_i, .tx_l0s_allow_o, .cfg_timeout_en_o, .other_timeout_en_o,
  .cpl_no_combine_o, .cpl_max_bytes_o
);
`default_nettype wire

// ---- dv/rpt_link_model.sv ----
// Purpose: link partner issuing inbound requests
// Assumes: one request at a time, launched after a rising edge
// Notes:   attributes packed as write, vc, ns, tph, tag, dca, peer, 4dw, low, hint
`timescale 1ns/1ns
`default_nettype none
module rpt_link_model (
  input  wire logic        ref_clk_i, // core clock
  output var  logic        valid_o, // request present
  output var  logic [17:0] req_o // packed attributes
);
  initial begin
    valid_o = 1'h0;
    req_o = 18'h00000;
  end
  task automatic send(input logic [17:0] r);
    @(posedge ref_clk_i);
    valid_o <= 1'h1;
    req_o <= r;
    @(posedge ref_clk_i);
    valid_o <= 1'h0;
    // Idle lines must not echo the last request
    req_o <= ~r;
  endtask
endmodule
`default_nettype wire

// ---- dv/test_rpt_policy_ctrl.sv ----
// Purpose: self-checking bench for rpt_policy_ctrl
// Assumes: DMI_PORT set so the hold refusal is reachable
// Notes:   expectations from reset values and write masks
`timescale 1ns/1ns
`default_nettype none
`include "rpt_regs.vh"
module test_rpt_policy_ctrl;
  logic        ref_clk_i = 1'h0, reset_i = 1'h1, dmi_mode_i = 1'h0, cfg_req_i = 1'h0, cfg_wr_i = 1'h0;
  logic        hold_msg_i = 1'h0, ob_valid_i = 1'h0, link_l0s_en_i = 1'h1;
  logic [11:0] cfg_addr_i = 12'h000;
  logic [3:0]  cfg_be_i = 4'hF;
  logic [31:0] cfg_wdata_i = 32'h00000000;
  logic [2:0]  ob_tc_i = 3'h0;
  wire logic   ib_valid_i, ib_write_i, ib_ns_i, ib_tph_i, ib_dca_match_i, ib_peer_i, ib_hdr4dw_i;
  wire logic   ib_addr_hi_zero_i, cip_hint_zero_i;
  wire logic [1:0]  ib_vc_i;
  wire logic [7:0]  ib_tag_i;
  wire logic [17:0] ib_req;
  logic        cfg_ack_o, fab_valid_o, fab_prefetch_o, fab_dca_en_o, fab_abort_o, malformed_o, rd_inorder_o;
  logic        hold_ur_o, fatal_err_o, ob_valid_o, tx_l0s_allow_o, cfg_timeout_en_o, other_timeout_en_o;
  logic        lbw_irq_allow_o, cpl_no_combine_o;
  logic [31:0] cfg_rdata_o;
  logic [2:0]  fab_op_o, ob_tc_o;
  logic [7:0]  fab_dca_tgt_o;
  logic [6:0]  cpl_max_bytes_o;
  wire logic [12:0] levels = {tx_l0s_allow_o, cfg_timeout_en_o, other_timeout_en_o, lbw_irq_allow_o,
                              cpl_no_combine_o, rd_inorder_o, cpl_max_bytes_o};
  logic [11:0] ofs [4] = '{`RPT_OFS_POLICY_A, `RPT_OFS_POLICY_B, `RPT_OFS_MISC, 12'h18C};
  logic [31:0] rst [4] = '{`RPT_RST_POLICY_A, `RPT_RST_POLICY_B, `RPT_RST_MISC, 32'h00000000};
  logic [31:0] msk [4] = '{`RPT_WM_POLICY_A, `RPT_WM_POLICY_B, `RPT_WM_MISC, 32'h00000000};
  int          failures = 0, checks = 0;

  assign {ib_write_i, ib_vc_i, ib_ns_i, ib_tph_i, ib_tag_i, ib_dca_match_i, ib_peer_i, ib_hdr4dw_i,
          ib_addr_hi_zero_i, cip_hint_zero_i} = ib_req;
  always #5 ref_clk_i = ~ref_clk_i;

  rpt_link_model u_rpt_link_model (.ref_clk_i, .valid_o(ib_valid_i), .req_o(ib_req));
  rpt_policy_ctrl #(.DMI_PORT(1), .TAG_W(8'h08)) u_rpt_policy_ctrl (
    .ref_clk_i, .reset_i, .dmi_mode_i, .cfg_req_i, .cfg_wr_i, .cfg_addr_i, .cfg_be_i, .cfg_wdata_i, .cfg_ack_o,
    .cfg_rdata_o, .ib_valid_i, .ib_write_i, .ib_vc_i, .ib_ns_i, .ib_tph_i, .ib_tag_i, .ib_dca_match_i, .ib_peer_i,
    .ib_hdr4dw_i, .ib_addr_hi_zero_i, .cip_hint_zero_i, .hold_msg_i, .ob_valid_i, .ob_tc_i, .link_l0s_en_i,
    .fab_valid_o, .fab_op_o, .fab_prefetch_o, .fab_dca_en_o, .fab_dca_tgt_o, .fab_abort_o, .malformed_o,
    .rd_inorder_o, .hold_ur_o, .fatal_err_o, .ob_valid_o, .ob_tc_o, .tx_l0s_allow_o, .cfg_timeout_en_o,
    .other_timeout_en_o, .lbw_irq_allow_o, .cpl_no_combine_o, .cpl_max_bytes_o);

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic print_verdict;
    if (failures == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    cfg_req_i <= 1'h1;
    cfg_wr_i <= w;
    cfg_addr_i <= a;
    cfg_wdata_i <= d;
    @(posedge ref_clk_i);
    cfg_req_i <= 1'h0;
    #1 chk("cfg_ack", 32'h1, {31'h0, cfg_ack_o});
  endtask
  // x packs dca match, peer, long header, low address, zero-tag hint
  function automatic logic [17:0] mk(input logic w, input logic [1:0] vc, input logic ns, input logic tph,
                                     input logic [4:0] x);
    return {w, vc, ns, tph, 8'hA5, x};
  endfunction
  // flags: fabric request, abort, malformed
  task automatic ib(input logic [17:0] r, input logic [2:0] flags, input logic [2:0] op);
    u_rpt_link_model.send(r);
    #1 chk("ib_outcome", {29'h0, flags}, {29'h0, fab_valid_o, fab_abort_o, malformed_o});
    if (flags[2]) chk("fab_op", {29'h0, op}, {29'h0, fab_op_o});
  endtask
  task automatic ob(input logic [2:0] tc, input logic [2:0] e);
    @(posedge ref_clk_i);
    ob_valid_i <= 1'h1;
    ob_tc_i <= tc;
    @(posedge ref_clk_i);
    ob_valid_i <= 1'h0;
    #1 chk("ob_tc", {28'h0, 1'h1, e}, {28'h0, ob_valid_o, ob_tc_o});
  endtask

  initial begin
    #900000;
    failures++;
    print_verdict;
  end
  initial begin
    repeat (8) @(posedge ref_clk_i);
    reset_i <= 1'h0;
    for (int i = 0; i < 4; i++) begin
      acc(1'h0, ofs[i], 32'h0);
      chk("reset_value", rst[i], cfg_rdata_o);
    end
    chk("levels", {19'h0, 13'h1E00}, {19'h0, levels});
    for (int i = 0; i < 4; i++) begin
      acc(1'h1, ofs[i], 32'hFFFFFFFF);
      acc(1'h0, ofs[i], 32'h0);
      chk("write_mask", msk[i], cfg_rdata_o);
    end
    chk("levels", {19'h0, 13'h01C0}, {19'h0, levels});
    @(posedge ref_clk_i);
    cfg_be_i <= 4'h2;
    acc(1'h1, ofs[0], 32'h0);
    @(posedge ref_clk_i);
    cfg_be_i <= 4'hF;
    acc(1'h0, ofs[0], 32'h0);
    chk("byte_lane", 32'h001F00FF, cfg_rdata_o);
    ib(mk(1'h1, 2'h0, 1'h0, 1'h0, 5'h00), 3'h4, `RPT_OP_DCA_WR);
    chk("dca_tgt", 32'hA5, {24'h0, fab_dca_tgt_o});
    chk("dca_en", 32'h1, {31'h0, fab_dca_en_o});
    ib(mk(1'h0, 2'h0, 1'h1, 1'h1, 5'h00), 3'h4, `RPT_OP_NS_RD);
    ib(mk(1'h0, 2'h1, 1'h1, 1'h0, 5'h00), 3'h4, `RPT_OP_NS_RD);
    ib(mk(1'h0, 2'h2, 1'h1, 1'h0, 5'h00), 3'h4, `RPT_OP_SNP_RD);
    ib(mk(1'h0, 2'h0, 1'h0, 1'h0, 5'h08), 3'h2, 3'h0);
    ib(mk(1'h1, 2'h0, 1'h0, 1'h0, 5'h06), 3'h1, 3'h0);
    ob(3'h5, 3'h0);
    @(posedge ref_clk_i);
    hold_msg_i <= 1'h1;
    @(posedge ref_clk_i);
    hold_msg_i <= 1'h0;
    #1 chk("hold_answer", 32'h3, {30'h0, hold_ur_o, fatal_err_o});
    for (int i = 0; i < 3; i++) acc(1'h1, ofs[i], 32'h0);
    // Levels settle one edge after the store edge
    repeat (2) @(posedge ref_clk_i);
    #1 chk("timeouts", 32'h1, {30'h0, cfg_timeout_en_o, other_timeout_en_o});
    ob(3'h5, 3'h5);
    ib(mk(1'h1, 2'h0, 1'h0, 1'h0, 5'h00), 3'h4, `RPT_OP_NALLOC_WR);
    chk("prefetch", 32'h1, {31'h0, fab_prefetch_o});
    chk("dca_en", 32'h0, {31'h0, fab_dca_en_o});
    ib(mk(1'h1, 2'h2, 1'h1, 1'h0, 5'h00), 3'h4, `RPT_OP_NS_WR);
    ib(mk(1'h0, 2'h1, 1'h1, 1'h0, 5'h00), 3'h4, `RPT_OP_SNP_RD);
    ib(mk(1'h0, 2'h0, 1'h1, 1'h0, 5'h00), 3'h4, `RPT_OP_SNP_RD);
    ib(mk(1'h1, 2'h0, 1'h0, 1'h1, 5'h00), 3'h4, `RPT_OP_HINT_WR);
    ib(mk(1'h0, 2'h0, 1'h1, 1'h1, 5'h00), 3'h4, `RPT_OP_HINT_RD);
    ib(mk(1'h1, 2'h0, 1'h0, 1'h0, 5'h06), 3'h4, `RPT_OP_NALLOC_WR);
    ib(mk(1'h0, 2'h0, 1'h0, 1'h0, 5'h08), 3'h4, `RPT_OP_SNP_RD);
    acc(1'h1, ofs[0], 32'h00000088);
    ib(mk(1'h1, 2'h0, 1'h1, 1'h0, 5'h00), 3'h4, `RPT_OP_NS_WR);
    ib(mk(1'h1, 2'h0, 1'h0, 1'h0, 5'h00), 3'h4, `RPT_OP_ALLOC_WR);
    chk("prefetch", 32'h0, {31'h0, fab_prefetch_o});
    ib(mk(1'h1, 2'h0, 1'h1, 1'h1, 5'h00), 3'h4, `RPT_OP_HINT_WR);
    ib(mk(1'h1, 2'h1, 1'h1, 1'h0, 5'h00), 3'h4, `RPT_OP_ALLOC_WR);
    @(posedge ref_clk_i);
    dmi_mode_i <= 1'h1;
    link_l0s_en_i <= 1'h0;
    // Mode pin crosses a two-stage synchroniser
    repeat (4) @(posedge ref_clk_i);
    ob(3'h5, 3'h0);
    chk("l0s_allow", 32'h0, {31'h0, tx_l0s_allow_o});
    print_verdict;
  end
endmodule
`default_nettype wire
